// File: rtl/mmd_pkg.sv
// package: constants for the memory map address decoder
package mmd_pkg;
  // ****************************************
  // address space
  // ****************************************
  localparam int unsigned ADDR_W       = 24;
  localparam int unsigned DATA_W       = 16;
  localparam logic [23:0] IRAM_BASE    = 24'h00F600;
  localparam logic [23:0] IRAM_LAST    = 24'h00FDFF;
  localparam logic [23:0] SFR_BASE     = 24'h00FE00;
  localparam logic [23:0] SFR_LAST     = 24'h00FFFF;
  localparam logic [23:0] EFR_BASE     = 24'h00F000;
  localparam logic [23:0] EFR_LAST     = 24'h00F1FF;
  localparam logic [23:0] EXTENSION_RAM_BASE    = 24'h00E000;
  localparam logic [23:0] EXTENSION_RAM_LAST    = 24'h00E7FF;
  localparam logic [23:0] CAN_BASE     = 24'h00EF00;
  localparam logic [23:0] CAN_LAST     = 24'h00EFFF;
  localparam int unsigned IRAM_WORDS   = 1024;
  localparam int unsigned IRAM_AW      = 10;
  localparam int unsigned GPR_WORDS    = 16;
  localparam int unsigned CFG_PEN_BIT  = 2;
  localparam int unsigned NWIN         = 4;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_NS       = 100;
  localparam int unsigned CPU_REF_NS   = 40;
  localparam int unsigned EXTENSION_RAM_NS      = 80;
  localparam int unsigned CAN_NS       = 160;
  // wait states are counted in cpu cycles of the reference clock beyond the base two
  localparam int unsigned EXTENSION_RAM_WAITS   = EXTENSION_RAM_NS / CPU_REF_NS - 2;
  localparam int unsigned CAN_WAITS    = CAN_NS / CPU_REF_NS - 2;
  localparam logic [1:0]  EXTENSION_RAM_WAIT_C  = EXTENSION_RAM_WAITS[1:0];
  localparam logic [1:0]  CAN_WAIT_C   = CAN_WAITS[1:0];
  // ****************************************
  // segment line counts
  // ****************************************
  localparam logic [3:0]  SEG_LINES_16M = 4'h8;
  localparam logic [3:0]  SEG_LINES_CAN = 4'h4;
  typedef enum logic [1:0] { MMD_SEG16M, MMD_SEG1M, MMD_SEG256K, MMD_SEG64K } mmd_seg_e;
  typedef enum logic [2:0] { MMD_T_IRAM, MMD_T_SFR, MMD_T_EXTENSION_RAM, MMD_T_CAN, MMD_T_EXT } mmd_tgt_e;
endpackage : mmd_pkg

// File: rtl/mmd_iram.sv
// dual-port internal ram with registered read data
`timescale 1ns/100ps
module mmd_iram (
  // clock
  input  wire logic                       clock_i,
  // port a: cpu side
  input  wire logic                       a_en_i,
  input  wire logic                       a_we_i,
  input  wire logic [1:0]                 a_be_i,
  input  wire logic [mmd_pkg::IRAM_AW-1:0] a_addr_i,
  input  wire logic [15:0]                a_wdata_i,
  output      logic [15:0]                a_rdata_o,
  // port b: register bank side, read only
  input  wire logic [mmd_pkg::IRAM_AW-1:0] b_addr_i,
  output      logic [15:0]                b_rdata_o
);
  logic [15:0] mem [mmd_pkg::IRAM_WORDS];
  // both byte lanes are written from one process so the array keeps a single writer
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < 2; i++) begin
      if (a_en_i && a_we_i && a_be_i[i]) begin
        mem[a_addr_i][i*8 +: 8] <= a_wdata_i[i*8 +: 8];
      end
    end
  end
  always_ff @(posedge clock_i) begin
    a_rdata_o <= mem[a_addr_i];
    b_rdata_o <= mem[b_addr_i];
  end
endmodule : mmd_iram

// File: rtl/mmd_decoder.sv
// memory map address decoder with internal ram, target steering and wait states
`timescale 1ns/100ps
module mmd_decoder (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // configuration
  input  wire logic [15:0] system_config_reg_i,
  input  wire logic [1:0]  seg_space_i,
  input  wire logic [23:0] win_base_i [4],
  input  wire logic [23:0] win_mask_i [4],
  input  wire logic [3:0]  win_en_i,
  // cpu request
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic        byte_i,
  input  wire logic        bit_op_i,
  input  wire logic        stack_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [15:0] cp_i,
  input  wire logic [3:0]  gpr_sel_i,
  input  wire logic        gpr_byte_i,
  output      logic        ready_o,
  output      logic [15:0] rdata_o,
  output      logic        fault_o,
  // register bank read port
  output      logic [15:0] gpr_data_o,
  // function register areas
  output      logic        sfr_sel_o,
  output      logic        efr_sel_o,
  input  wire logic [15:0] sfr_rdata_i,
  // extension bus targets
  output      logic        extension_ram_sel_o,
  output      logic        can_sel_o,
  input  wire logic [15:0] onchip_rdata_i,
  // external bus controller
  output      logic        ext_req_o,
  output      logic [2:0]  ext_window_o,
  output      logic [3:0]  seg_lines_o,
  input  wire logic        ext_ready_i,
  input  wire logic [15:0] ext_rdata_i,
  // common access attributes
  output      logic [23:0] addr_o,
  output      logic        we_o,
  output      logic [1:0]  be_o
);
  // ****************************************
  // range decoding
  // ****************************************
  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  wire pen      = system_config_reg_i[mmd_pkg::CFG_PEN_BIT];
  wire hit_iram = in_range(addr_i, mmd_pkg::IRAM_BASE, mmd_pkg::IRAM_LAST);
  wire hit_sfr  = in_range(addr_i, mmd_pkg::SFR_BASE, mmd_pkg::SFR_LAST);
  wire hit_efr  = in_range(addr_i, mmd_pkg::EFR_BASE, mmd_pkg::EFR_LAST);
  wire hit_extension_ram = pen && in_range(addr_i, mmd_pkg::EXTENSION_RAM_BASE, mmd_pkg::EXTENSION_RAM_LAST);
  wire hit_can  = pen && in_range(addr_i, mmd_pkg::CAN_BASE, mmd_pkg::CAN_LAST);
  // the extension ram looks external, so stack and bit operations there are refused
  wire bad_extension_ram = hit_extension_ram && (stack_i || bit_op_i);
  // anything else, including a disabled extension window, goes outside
  wire hit_ext  = !(hit_iram || hit_sfr || hit_efr || hit_extension_ram || hit_can);

  // ****************************************
  // external windows
  // ****************************************
  logic [3:0] win_hit;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_win
      assign win_hit[g] = win_en_i[g] &&
                          ((addr_i & win_mask_i[g]) == (win_base_i[g] & win_mask_i[g]));
    end
  endgenerate
  // window four over three, two over one; no hit means the default window 0
  wire [2:0] win_sel = win_hit[3] ? 3'h4 : win_hit[2] ? 3'h3 :
                       win_hit[1] ? 3'h2 : win_hit[0] ? 3'h1 : 3'h0;

  // ****************************************
  // segment lines
  // ****************************************
  wire [3:0] seg_space_lines = (seg_space_i == mmd_pkg::MMD_SEG16M)  ? mmd_pkg::SEG_LINES_16M :
                               (seg_space_i == mmd_pkg::MMD_SEG1M)   ? 4'h4 :
                               (seg_space_i == mmd_pkg::MMD_SEG256K) ? 4'h2 : 4'h0;
  // with the can window active at most four segment lines remain
  wire [3:0] seg_lines = (pen && seg_space_lines > mmd_pkg::SEG_LINES_CAN) ?
                         mmd_pkg::SEG_LINES_CAN : seg_space_lines;

  // ****************************************
  // access state machine
  // ****************************************
  typedef enum logic [1:0] { MMD_IDLE, MMD_WAIT, MMD_EXT, MMD_DONE } mmd_state_e;
  mmd_state_e  state_reg, state_next;
  mmd_pkg::mmd_tgt_e tgt_reg, tgt_next;
  logic [1:0]  wait_reg, wait_next;
  logic [23:0] addr_reg;
  logic        we_reg, fault_reg, fault_next;
  logic [1:0]  be_reg;
  logic [15:0] wdata_reg, rdata_reg, rdata_next;
  logic [2:0]  win_reg;

  // word accesses use both lanes, bytes pick by address bit 0
  wire [1:0] be_req = byte_i ? (addr_i[0] ? 2'h2 : 2'h1) : 2'h3;
  wire       start  = (state_reg == MMD_IDLE) && req_i;

  mmd_pkg::mmd_tgt_e tgt_dec;
  // an if chain keeps every arm typed as the target enum
  always_comb begin
    if (hit_iram) begin
      tgt_dec = mmd_pkg::MMD_T_IRAM;
    end else if (hit_sfr || hit_efr) begin
      tgt_dec = mmd_pkg::MMD_T_SFR;
    end else if (hit_extension_ram) begin
      tgt_dec = mmd_pkg::MMD_T_EXTENSION_RAM;
    end else if (hit_can) begin
      tgt_dec = mmd_pkg::MMD_T_CAN;
    end else begin
      tgt_dec = mmd_pkg::MMD_T_EXT;
    end
  end

  always_comb begin
    state_next = state_reg;
    tgt_next   = tgt_reg;
    wait_next  = wait_reg;
    fault_next = fault_reg;
    case (state_reg)
      MMD_IDLE: begin
        if (req_i) begin
          tgt_next   = tgt_dec;
          fault_next = bad_extension_ram;
          if (hit_ext) begin
            state_next = MMD_EXT;
          end else if (hit_can) begin
            wait_next  = mmd_pkg::CAN_WAIT_C;
            state_next = MMD_WAIT;
          end else begin
            wait_next  = mmd_pkg::EXTENSION_RAM_WAIT_C;
            state_next = MMD_DONE;
          end
        end
      end
      MMD_WAIT: begin
        wait_next = wait_reg - 2'h1;
        if (wait_reg == 2'h1) begin
          state_next = MMD_DONE;
        end
      end
      MMD_EXT: begin
        if (ext_ready_i) begin
          state_next = MMD_DONE;
        end
      end
      default: begin
        state_next = MMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_reg <= MMD_IDLE;
      tgt_reg   <= mmd_pkg::MMD_T_EXT;
      wait_reg  <= 2'h0;
      fault_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tgt_reg   <= tgt_next;
      wait_reg  <= wait_next;
      fault_reg <= fault_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      addr_reg  <= 24'h000000;
      we_reg    <= 1'b0;
      be_reg    <= 2'h0;
      wdata_reg <= 16'h0000;
      win_reg   <= 3'h0;
    end else if (start) begin
      addr_reg  <= addr_i;
      we_reg    <= we_i && !bad_extension_ram;
      be_reg    <= be_req;
      wdata_reg <= wdata_i;
      win_reg   <= win_sel;
    end
  end

  // ****************************************
  // internal ram and register bank
  // ****************************************
  wire [mmd_pkg::IRAM_AW-1:0] iram_waddr = addr_reg[mmd_pkg::IRAM_AW:1];
  // the read is launched at the request edge, so its word already stands in the ready cycle
  wire [mmd_pkg::IRAM_AW-1:0] iram_addr  = start ? addr_i[mmd_pkg::IRAM_AW:1] : iram_waddr;
  // register n sits at cp + 2n; byte registers share the word of register n/2
  wire [15:0] gpr_byte_addr = cp_i + {11'h000, (gpr_byte_i ? {1'b0, gpr_sel_i[3:1]} :
                                                  gpr_sel_i), 1'b0};
  wire [mmd_pkg::IRAM_AW-1:0] gpr_waddr = gpr_byte_addr[mmd_pkg::IRAM_AW:1];
  wire [15:0] iram_rdata;
  wire [15:0] gpr_word;
  logic       gpr_hi_reg;

  mmd_iram u_iram (
    .clock_i   (clock_i),
    .a_en_i    (state_reg == MMD_DONE && tgt_reg == mmd_pkg::MMD_T_IRAM),
    .a_we_i    (we_reg),
    .a_be_i    (be_reg),
    .a_addr_i  (iram_addr),
    .a_wdata_i (wdata_reg),
    .a_rdata_o (iram_rdata),
    .b_addr_i  (gpr_waddr),
    .b_rdata_o (gpr_word)
  );

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      gpr_hi_reg <= 1'b0;
    end else begin
      gpr_hi_reg <= gpr_byte_i && gpr_sel_i[0];
    end
  end
  // low byte registers are even selects, high byte registers odd
  assign gpr_data_o = gpr_hi_reg ? {8'h00, gpr_word[15:8]} : gpr_word;

  // ****************************************
  // read data and outputs
  // ****************************************
  always_comb begin
    rdata_next = rdata_reg;
    if (state_reg == MMD_DONE) begin
      case (tgt_reg)
        mmd_pkg::MMD_T_IRAM: rdata_next = iram_rdata;
        mmd_pkg::MMD_T_SFR:  rdata_next = sfr_rdata_i;
        mmd_pkg::MMD_T_EXT:  rdata_next = ext_rdata_i;
        default:             rdata_next = fault_reg ? 16'h0000 : onchip_rdata_i;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  wire busy  = state_reg != MMD_IDLE;
  assign ready_o      = state_reg == MMD_DONE;
  assign fault_o      = ready_o && fault_reg;
  assign rdata_o      = rdata_reg;
  assign sfr_sel_o    = busy && tgt_reg == mmd_pkg::MMD_T_SFR;
  assign efr_sel_o    = sfr_sel_o && addr_reg < mmd_pkg::SFR_BASE;
  assign extension_ram_sel_o   = busy && tgt_reg == mmd_pkg::MMD_T_EXTENSION_RAM && !fault_reg;
  assign can_sel_o    = busy && tgt_reg == mmd_pkg::MMD_T_CAN;
  assign ext_req_o    = state_reg == MMD_EXT;
  assign ext_window_o = win_reg;
  assign seg_lines_o  = seg_lines;
  assign addr_o       = addr_reg;
  assign we_o         = we_reg;
  assign be_o         = be_reg;

  // ****************************************
  // checks
  // ****************************************
  sequence can_wait_s;
    state_reg == MMD_WAIT ##1 state_reg == MMD_WAIT ##1 state_reg == MMD_DONE;
  endsequence

  can_waits_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    start && hit_can |=> can_wait_s) else $error("can access not two waits");
  extension_ram_fast_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    start && hit_extension_ram |=> ready_o) else $error("extension_ram access not one cycle");
  extension_ram_off_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    start && !pen && in_range(addr_i, mmd_pkg::EXTENSION_RAM_BASE, mmd_pkg::EXTENSION_RAM_LAST)
    |=> ext_req_o) else $error("disabled extension_ram not external");
  extension_ram_guard_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    start && hit_extension_ram && bit_op_i |=> !extension_ram_sel_o && !we_o) else $error("bit op on extension_ram");
  win_prio_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    start && win_hit[3] |=> ext_window_o == 3'h4) else $error("window priority");
  seg_can_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    pen |-> seg_lines_o <= 4'h4) else $error("segment lines with can");
  ext_fwd_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    start && hit_ext |=> ext_req_o && addr_o == $past(addr_i)) else $error("ext forward");
  byte_lane_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    start && byte_i |=> be_o != 2'h3) else $error("byte access as word");
  sfr_route_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    start && hit_sfr |=> sfr_sel_o && !ext_req_o) else $error("sfr route");
endmodule : mmd_decoder

// File: bench/mmd_ebc_model.sv
// external bus controller model answering after a programmable delay
`timescale 1ns/100ps
module mmd_ebc_model (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // access from the decoder
  input  wire logic        ext_req_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [3:0]  delay_i,
  // answer
  output      logic        ext_ready_o,
  output      logic [15:0] ext_rdata_o
);
  logic [3:0]  wait_reg;
  logic [15:0] last_reg;
  logic        answer;

  assign answer = ext_req_i && !ext_ready_o && (wait_reg == delay_i);

  // data holds one cycle past ready, since the decoder samples it in its own ready cycle
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      wait_reg    <= 4'h0;
      last_reg    <= 16'h0000;
      ext_ready_o <= 1'b0;
      ext_rdata_o <= 16'hFFFF;
    end else if (answer) begin
      wait_reg    <= 4'h0;
      last_reg    <= addr_i[15:0] ^ 16'hC35A;
      ext_ready_o <= 1'b1;
      ext_rdata_o <= addr_i[15:0] ^ 16'hC35A;
    end else begin
      wait_reg    <= (ext_req_i && !ext_ready_o) ? wait_reg + 4'h1 : 4'h0;
      ext_ready_o <= 1'b0;
      // a released bus must not keep showing the last word
      ext_rdata_o <= ext_ready_o ? ext_rdata_o : ~last_reg;
    end
  end
endmodule : mmd_ebc_model

// File: bench/mmd_decoder_tb_top.sv
// self-checking testbench for the memory map address decoder
`timescale 1ns/100ps
module mmd_decoder_tb_top;
  typedef struct packed {
    logic [23:0] addr;
    logic        pen;
    logic [4:0]  sel;
    logic [2:0]  lat;
    logic [2:0]  win;
  } mmd_row_s;

  // ****************************************
  // expected routing, one access per row
  // ****************************************
  localparam mmd_row_s ROWS [14] = '{
    '{24'h00FE10, 1'b1, 5'h10, 3'h1, 3'h0}, '{24'h00F1FE, 1'b1, 5'h18, 3'h1, 3'h0},
    '{24'h00E000, 1'b1, 5'h04, 3'h1, 3'h0}, '{24'h00E7FF, 1'b1, 5'h04, 3'h1, 3'h0},
    '{24'h00E800, 1'b1, 5'h01, 3'h0, 3'h0}, '{24'h00EF00, 1'b1, 5'h02, 3'h3, 3'h0},
    '{24'h00EFFF, 1'b1, 5'h02, 3'h3, 3'h0}, '{24'h00E000, 1'b0, 5'h01, 3'h0, 3'h0},
    '{24'h00EF00, 1'b0, 5'h01, 3'h0, 3'h0}, '{24'h150000, 1'b0, 5'h01, 3'h0, 3'h1},
    '{24'h123456, 1'b0, 5'h01, 3'h0, 3'h2}, '{24'h250000, 1'b1, 5'h01, 3'h0, 3'h3},
    '{24'h234567, 1'b1, 5'h01, 3'h0, 3'h4}, '{24'hFFFFFF, 1'b0, 5'h01, 3'h0, 3'h0}};
  localparam logic [3:0] SEG [4] = '{4'h8, 4'h4, 4'h2, 4'h0};

  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [15:0] cfg = 16'h0000;
  logic [1:0]  seg_space = 2'h0;
  logic [23:0] win_base [4];
  logic [23:0] win_mask [4];
  logic        req = 1'b0, we = 1'b0, byt = 1'b0, bit_op = 1'b0, stack = 1'b0;
  logic [23:0] addr = 24'h000000;
  logic [15:0] wdata = 16'h0000, cp = 16'hF600;
  logic [3:0]  gpr_sel = 4'h3, pdelay = 4'h0, win_en = 4'hF;
  logic        gpr_byte = 1'b0;
  logic        ready, fault, sfr_sel, efr_sel, extension_ram_sel, can_sel, ext_req, ext_ready, we_o;
  logic [15:0] rdata, gpr_data, ext_rdata;
  logic [2:0]  ext_window;
  logic [3:0]  seg_lines;
  logic [23:0] addr_o;
  logic [1:0]  be_o;
  int          bad_count = 0;
  int          checks = 0;

  always #50 clock_i = ~clock_i;

  mmd_decoder dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .system_config_reg_i(cfg), .seg_space_i(seg_space),
    .win_base_i(win_base), .win_mask_i(win_mask), .win_en_i(win_en), .req_i(req), .we_i(we),
    .byte_i(byt), .bit_op_i(bit_op), .stack_i(stack), .addr_i(addr), .wdata_i(wdata),
    .cp_i(cp), .gpr_sel_i(gpr_sel), .gpr_byte_i(gpr_byte), .ready_o(ready), .rdata_o(rdata),
    .fault_o(fault), .gpr_data_o(gpr_data), .sfr_sel_o(sfr_sel), .efr_sel_o(efr_sel),
    .sfr_rdata_i(16'hA5C3), .extension_ram_sel_o(extension_ram_sel), .can_sel_o(can_sel),
    .onchip_rdata_i(16'h5A3C), .ext_req_o(ext_req), .ext_window_o(ext_window),
    .seg_lines_o(seg_lines), .ext_ready_i(ext_ready), .ext_rdata_i(ext_rdata),
    .addr_o(addr_o), .we_o(we_o), .be_o(be_o));

  mmd_ebc_model ebc (
    .clock_i(clock_i), .rstn_i(rstn_i), .ext_req_i(ext_req), .addr_i(addr_o),
    .delay_i(pdelay), .ext_ready_o(ext_ready), .ext_rdata_o(ext_rdata));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [15:0] exp_rd(input logic [4:0] sel, input logic [23:0] a);
    if (sel[4] || sel[3]) return 16'hA5C3;
    if (sel[2] || sel[1]) return 16'h5A3C;
    return a[15:0] ^ 16'hC35A;
  endfunction : exp_rd

  // one access; lat of zero leaves the answer time to the far side
  task automatic acc(input logic [23:0] a, input logic w, input logic b, input logic s,
                     input logic bo, input logic [15:0] wd, input logic [4:0] sel,
                     input logic [2:0] lat, input logic [2:0] win, input logic flt,
                     output logic [15:0] rd);
    int n;
    {addr, we, byt, stack, bit_op, wdata, req} = {a, w, b, s, bo, wd, 1'b1};
    @(negedge clock_i);
    req = 1'b0;
    check(24'({sfr_sel, efr_sel, extension_ram_sel, can_sel, ext_req}), 24'(sel));
    check(addr_o, a);
    check(24'(be_o), 24'(b ? (a[0] ? 2'b10 : 2'b01) : 2'b11));
    check(24'(we_o), 24'(w & ~flt));
    n = 1;
    while (ready !== 1'b1 && n < 40) begin
      @(negedge clock_i);
      n++;
    end
    if (ready !== 1'b1) begin
      bad_count++;
      end_of_test();
    end
    if (lat != 3'h0) check(24'(n), 24'(lat));
    check(24'(fault), 24'(flt));
    if (sel == 5'h01) check(24'(ext_window), 24'(win));
    @(negedge clock_i);
    rd = rdata;
  endtask : acc

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [15:0] rd;
    win_base = '{24'h100000, 24'h120000, 24'h200000, 24'h230000};
    win_mask = '{24'hF00000, 24'hFF0000, 24'hF00000, 24'hFF0000};
    repeat (5) @(negedge clock_i);
    rstn_i = 1'b1;
    for (int i = 0; i < 14; i++) begin
      cfg = ROWS[i].pen ? 16'h0004 : 16'h0000;
      pdelay = 4'(i % 4);
      acc(ROWS[i].addr, 1'b0, ROWS[i].addr[0], 1'b0, 1'b0, 16'h0000, ROWS[i].sel,
          ROWS[i].lat, ROWS[i].win, 1'b0, rd);
      if (!ROWS[i].addr[0]) check(24'(rd), 24'(exp_rd(ROWS[i].sel, ROWS[i].addr)));
    end
    // segment lines for each space, then capped while the window enable is set
    for (int s = 0; s < 8; s++) begin
      seg_space = 2'(s % 4);
      cfg = (s > 3) ? 16'h0004 : 16'h0000;
      #1;
      check(24'(seg_lines), 24'((s > 3 && SEG[s % 4] > 4'h4) ? 4'h4 : SEG[s % 4]));
      @(negedge clock_i);
    end
    // internal ram word then high byte write, read back through both ports
    acc(24'h00F606, 1'b1, 1'b0, 1'b0, 1'b0, 16'hBEEF, 5'h00, 3'h1, 3'h0, 1'b0, rd);
    acc(24'h00F607, 1'b1, 1'b1, 1'b0, 1'b0, 16'h7777, 5'h00, 3'h1, 3'h0, 1'b0, rd);
    // a different word in between, so a late read would show the wrong data
    acc(24'h00F808, 1'b1, 1'b0, 1'b0, 1'b0, 16'h1357, 5'h00, 3'h1, 3'h0, 1'b0, rd);
    acc(24'h00F606, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 5'h00, 3'h1, 3'h0, 1'b0, rd);
    check(24'(rd), 24'h0077EF);
    repeat (2) @(negedge clock_i);
    check(24'(gpr_data), 24'h0077EF);
    // high byte register of pair three
    {gpr_byte, gpr_sel} = {1'b1, 4'h7};
    repeat (2) @(negedge clock_i);
    check(24'(gpr_data), 24'h000077);
    // stack and bit accesses onto extension ram are refused
    cfg = 16'h0004;
    acc(24'h00E010, 1'b1, 1'b0, 1'b1, 1'b0, 16'h1234, 5'h00, 3'h1, 3'h0, 1'b1, rd);
    acc(24'h00E012, 1'b1, 1'b0, 1'b0, 1'b1, 16'h1234, 5'h00, 3'h1, 3'h0, 1'b1, rd);
    // with window four switched off, window three takes the access
    win_en = 4'h7;
    acc(24'h234567, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000, 5'h01, 3'h0, 3'h3, 1'b0, rd);
    // reset in the middle of a slow access
    {addr, we, req} = {24'h00EF10, 1'b0, 1'b1};
    @(negedge clock_i);
    req = 1'b0;
    rstn_i = 1'b0;
    repeat (5) @(negedge clock_i);
    check(24'({ready, fault, sfr_sel, efr_sel, extension_ram_sel, can_sel, ext_req}), 24'h0);
    rstn_i = 1'b1;
    acc(24'h00FE20, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 5'h10, 3'h1, 3'h0, 1'b0, rd);
    end_of_test();
  end
endmodule : mmd_decoder_tb_top
